// File: hw/icb_map.vh
/*
 * Register offsets, field positions, reset values and timing constants of the
 * two-wire master collision and baud block.
 * Assumes a plain register port with one-cycle strobes and a 25 MHz system clock.
 */
// Function
// - Repeated Start: SDA low when SCL rises flags a collision.
// - Repeated Start: SCL falling before we pull SDA low flags a collision.
// - Repeated Start: release SDA, count, release SCL, sample SDA once SCL high.
// - Repeated Start: SDA high then reload; SDA falling before expiry is fine.
// - Repeated Start: SCL falling before expiry, SDA not driven, flags collision.
// - Both high at expiry: drive SDA low, count, then drive SCL low.
// - Stop: SDA still low after count following release flags a collision.
// - Stop: SCL low after release but before SDA high flags collision.
// - Stop: drive SDA low, release SCL, on SCL high count, release SDA, count, then sample SDA.
// - One baud counter, reloaded from the reload register, serves I2C and SPI.
// - Writing the transfer buffer starts the baud counter.
// - On completion the counter stops and the clock keeps its last level.
// - Counter reloads twice per serial clock period.
// - Serial clock equals system clock over four times the sum of reload and one.
// - Any collision sets the collision flag and idles the port.
// - Collision in a condition aborts it, frees lines, clears its enable.
// - Stop-seen bit reads one when the last condition seen was a Stop.
`ifndef ICB_MAP_VH
`define ICB_MAP_VH

// Register offsets
`define ICB_ADDR_CTRL 4'h0
`define ICB_ADDR_RELOAD 4'h1
`define ICB_ADDR_BUF 4'h2
`define ICB_ADDR_STATUS 4'h3
`define ICB_ADDR_INT_STAT 4'h4
`define ICB_ADDR_INT_MASK 4'h5

// Control fields
`define ICB_CTRL_RSEN 0
`define ICB_CTRL_PEN 1
`define ICB_CTRL_SPI 2

// Status fields
`define ICB_STAT_BUSY 0
`define ICB_STAT_START 3
`define ICB_STAT_STOP 4

// Interrupt fields
`define ICB_INT_COLL 0
`define ICB_INT_DONE 1

// Reset values
`define ICB_RELOAD_RST 8'h13
`define ICB_STATUS_RST 8'h00

// Each baud period is reload+1 counts of a 4-phase reference; each count takes two clocks here
`define ICB_CLK_PER_CNT 2

`endif

// File: hw/icb_baud_gen.v
/*
 * Shared baud counter: loads the reload value and counts down to zero.
 * Assumes the controller raises load for one cycle to start a half period.
 */
module icb_baud_gen #(
    parameter WIDTH = 8,
    parameter PRE = 2
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Control
    input wire i_load,
    input wire i_stop,
    input wire [WIDTH-1:0] i_reload,
    // Status
    output reg o_expire,
    output reg o_run
);
    reg [WIDTH-1:0] cnt_r;
    reg [1:0] pre_r;

    // Half period is (reload+1)*2 system clocks, so full period is 4*(reload+1)
    always @(posedge i_clk_sys) begin
        if (i_rst || i_stop) begin
            cnt_r <= {WIDTH{1'b0}};
            pre_r <= 2'h0;
            o_run <= 1'b0;
        end else if (i_load) begin
            cnt_r <= i_reload;
            pre_r <= 2'h0;
            o_run <= 1'b1;
        end else if (o_run) begin
            if (pre_r != 2'h0) begin
                pre_r <= pre_r - 2'h1;
            end else if (cnt_r != {WIDTH{1'b0}}) begin
                cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
                pre_r <= PRE[1:0] - 2'h1;
            end else begin
                o_run <= 1'b0;
            end
        end
    end

    // Expiry shows in the zero cycle itself, so load plus count is exactly PRE*(reload+1)
    always @* begin
        o_expire = o_run && (pre_r == 2'h0) && (cnt_r == {WIDTH{1'b0}});
    end
endmodule // icb_baud_gen

// File: hw/icb_master.v
/*
 * Two-wire master condition sequencer with collision detection for Repeated
 * Start and Stop, plus SPI clocking, on one shared baud counter.
 * Assumes synchronous bus line inputs and a single-cycle register port.
 */
`include "icb_map.vh"

module icb_master #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Bus lines
    input wire i_scl,
    input wire i_sda,
    output reg o_scl_oe,
    output reg o_sda_oe,
    output reg o_scl_o,
    output reg o_sda_o,
    // Interrupt
    output reg o_irq
);
    localparam [9:0] ST_IDLE = 10'h001;
    localparam [9:0] ST_RS_REL = 10'h002;
    localparam [9:0] ST_RS_SCLH = 10'h004;
    localparam [9:0] ST_RS_HOLD = 10'h008;
    localparam [9:0] ST_RS_SDAL = 10'h010;
    localparam [9:0] ST_P_SDAL = 10'h020;
    localparam [9:0] ST_P_SCLH = 10'h040;
    localparam [9:0] ST_P_CNT = 10'h080;
    localparam [9:0] ST_P_REL = 10'h100;
    localparam [9:0] ST_XFER = 10'h200;

    reg [9:0] state_r;
    reg [7:0] reload_r;
    reg [7:0] buf_r;
    reg rsen_r;
    reg pen_r;
    reg spi_r;
    reg stop_seen_r;
    reg start_seen_r;
    reg [1:0] int_stat_r;
    reg [1:0] int_mask_r;
    reg scl_drv_r;
    reg sda_drv_r;
    reg scl_q_r;
    reg sda_q_r;
    reg [4:0] edge_cnt_r;
    reg load_r;
    reg stop_cnt_r;
    reg coll_r;
    reg done_r;
    wire expire;
    wire run;

    function wr_hit;
        input [3:0] a;
        begin
            wr_hit = i_wr && (i_addr == a);
        end
    endfunction

    icb_baud_gen #(
        .WIDTH(WIDTH),
        .PRE(`ICB_CLK_PER_CNT)
    ) u_baud (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_load(load_r),
        .i_stop(stop_cnt_r),
        .i_reload(reload_r),
        .o_expire(expire),
        .o_run(run)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Condition sequencer
    always @(posedge i_clk_sys) begin
        load_r <= 1'b0;
        stop_cnt_r <= 1'b0;
        coll_r <= 1'b0;
        done_r <= 1'b0;
        scl_q_r <= i_scl;
        sda_q_r <= i_sda;
        if (i_rst) begin
            state_r <= ST_IDLE;
            rsen_r <= 1'b0;
            pen_r <= 1'b0;
            spi_r <= 1'b0;
            reload_r <= `ICB_RELOAD_RST;
            buf_r <= 8'h00;
            scl_drv_r <= 1'b0;
            sda_drv_r <= 1'b0;
            stop_seen_r <= 1'b0;
            start_seen_r <= 1'b0;
            edge_cnt_r <= 5'h00;
        end else begin
            if (wr_hit(`ICB_ADDR_RELOAD)) begin
                reload_r <= i_wdata;
            end
            if (wr_hit(`ICB_ADDR_CTRL)) begin
                spi_r <= i_wdata[`ICB_CTRL_SPI];
            end
            case (state_r)
                ST_IDLE: begin
                    if (wr_hit(`ICB_ADDR_CTRL) && i_wdata[`ICB_CTRL_RSEN]) begin
                        rsen_r <= 1'b1;
                        sda_drv_r <= 1'b0;
                        load_r <= 1'b1;
                        state_r <= ST_RS_REL;
                    end else if (wr_hit(`ICB_ADDR_CTRL) && i_wdata[`ICB_CTRL_PEN]) begin
                        pen_r <= 1'b1;
                        sda_drv_r <= 1'b1;
                        state_r <= ST_P_SDAL;
                    end else if (wr_hit(`ICB_ADDR_BUF)) begin
                        buf_r <= i_wdata;
                        load_r <= 1'b1;
                        edge_cnt_r <= 5'h00;
                        state_r <= ST_XFER;
                    end
                end
                ST_RS_REL: begin
                    if (expire) begin
                        scl_drv_r <= 1'b0;
                        state_r <= ST_RS_SCLH;
                    end
                end
                ST_RS_SCLH: begin
                    if (i_scl) begin
                        if (!i_sda) begin
                            coll_r <= 1'b1;
                        end else begin
                            load_r <= 1'b1;
                            state_r <= ST_RS_HOLD;
                        end
                    end
                end
                ST_RS_HOLD: begin
                    if (scl_q_r && !i_scl && i_sda) begin
                        coll_r <= 1'b1;
                    end else if (!i_sda) begin
                        // Another master started first; not a collision
                        sda_drv_r <= 1'b1;
                        load_r <= 1'b1;
                        state_r <= ST_RS_SDAL;
                    end else if (expire && i_scl) begin
                        sda_drv_r <= 1'b1;
                        load_r <= 1'b1;
                        state_r <= ST_RS_SDAL;
                    end
                end
                ST_RS_SDAL: begin
                    if (expire) begin
                        scl_drv_r <= 1'b1;
                        rsen_r <= 1'b0;
                        start_seen_r <= 1'b1;
                        stop_seen_r <= 1'b0;
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_P_SDAL: begin
                    if (!i_sda) begin
                        scl_drv_r <= 1'b0;
                        state_r <= ST_P_SCLH;
                    end
                end
                ST_P_SCLH: begin
                    if (i_scl) begin
                        load_r <= 1'b1;
                        state_r <= ST_P_CNT;
                    end
                end
                ST_P_CNT: begin
                    if (!i_scl) begin
                        coll_r <= 1'b1;
                    end else if (expire) begin
                        sda_drv_r <= 1'b0;
                        load_r <= 1'b1;
                        state_r <= ST_P_REL;
                    end
                end
                ST_P_REL: begin
                    if (!i_scl && !i_sda) begin
                        coll_r <= 1'b1;
                    end else if (expire) begin
                        if (!i_sda) begin
                            coll_r <= 1'b1;
                        end else begin
                            pen_r <= 1'b0;
                            stop_seen_r <= 1'b1;
                            start_seen_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_XFER: begin
                    if (expire) begin
                        // Two reloads per clock period, one per edge
                        scl_drv_r <= ~scl_drv_r;
                        if (spi_r) begin
                            buf_r <= {buf_r[6:0], i_sda};
                        end
                        if (edge_cnt_r == 5'h0F) begin
                            done_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end else begin
                            edge_cnt_r <= edge_cnt_r + 5'h01;
                            load_r <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
            if (coll_r) begin
                // Abort: free both lines, clear enables, return to idle
                state_r <= ST_IDLE;
                rsen_r <= 1'b0;
                pen_r <= 1'b0;
                scl_drv_r <= 1'b0;
                sda_drv_r <= 1'b0;
                stop_cnt_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pins, interrupts and read port
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            int_stat_r <= 2'h0;
            int_mask_r <= 2'h0;
            o_rdata <= 8'h00;
            o_irq <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;
            o_scl_o <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            o_scl_oe <= scl_drv_r;
            o_sda_oe <= sda_drv_r;
            o_scl_o <= 1'b0;
            o_sda_o <= 1'b0;
            if (wr_hit(`ICB_ADDR_INT_MASK)) begin
                int_mask_r <= i_wdata[1:0];
            end
            // Set wins over write-one-to-clear
            int_stat_r <= (int_stat_r & ~(wr_hit(`ICB_ADDR_INT_STAT) ? i_wdata[1:0] : 2'h0))
                | {done_r, coll_r};
            o_irq <= |(int_stat_r & int_mask_r);
            o_rdata <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `ICB_ADDR_CTRL: o_rdata <= {5'h00, spi_r, pen_r, rsen_r};
                    `ICB_ADDR_RELOAD: o_rdata <= reload_r;
                    `ICB_ADDR_BUF: o_rdata <= buf_r;
                    `ICB_ADDR_STATUS: o_rdata <= {3'h0, stop_seen_r, start_seen_r, 2'h0, run};
                    `ICB_ADDR_INT_STAT: o_rdata <= {6'h00, int_stat_r};
                    `ICB_ADDR_INT_MASK: o_rdata <= {6'h00, int_mask_r};
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // icb_master

// File: sim/icb_master_props.sv
/* Port assertions for icb_master.
   Assumes binding from the bench and SDA left free while SPI shifts ones. */
module icb_master_props (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Bus lines
    input wire i_scl,
    input wire i_sda,
    input wire o_scl_oe,
    input wire o_sda_oe,
    input wire o_scl_o,
    input wire o_sda_o,
    // Interrupt
    input wire o_irq
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge i_clk_sys); endclocking
default disable iff (i_rst);
////////////////////////////////////////
sequence s_free;
    !o_scl_oe && !o_sda_oe;
endsequence
sequence s_scl_up_sda_low;
    $rose(i_scl) && !i_sda;
endsequence
property p_od; o_scl_o == 1'b0 && o_sda_o == 1'b0; endproperty
property p_rst; $fell(i_rst) |-> s_free ##0 !o_irq; endproperty
property p_rdz; !i_rd |=> o_rdata == 8'h00; endproperty
property p_hi; $rose(o_scl_oe) |=> $stable(o_scl_oe) [*6]; endproperty
property p_lo; $fell(o_scl_oe) |=> !o_scl_oe [*6]; endproperty
property p_rs_end; $rose(o_scl_oe) && o_sda_oe |-> $past(o_sda_oe, 6); endproperty
property p_stop; $fell(o_scl_oe) && o_sda_oe |-> !i_sda; endproperty
property p_c1; s_free ##0 s_scl_up_sda_low |=> s_free [*8]; endproperty
property p_c2; s_free ##0 ($fell(i_scl) && $past(i_sda)) |=> s_free [*4]; endproperty
a_od: assert property (p_od) else $error("line driven high");
a_rst: assert property (p_rst) else $error("outputs active after reset");
a_rdz: assert property (p_rdz) else $error("read data without read");
a_hi: assert property (p_hi) else $error("clock low phase too short");
a_lo: assert property (p_lo) else $error("clock high phase too short");
a_rs_end: assert property (p_rs_end) else $error("clock held before data hold");
a_stop: assert property (p_stop) else $error("clock freed before data low");
a_c1: assert property (p_c1) else $error("no abort on data low");
a_c2: assert property (p_c2) else $error("no abort on clock fall");
endmodule // icb_master_props

// File: sim/icb_bus_model.sv
/* Two-wire peer: pulled-up wires and another party that may hold either line low.
   Assumes the bench commands the peer's pulls just after clock edges. */
module icb_bus_model (
    // Design drive
    input wire logic i_scl_oe,
    input wire logic i_sda_oe,
    // Peer drive
    input wire logic i_pull_scl,
    input wire logic i_pull_sda,
    // Resolved wires
    output logic o_scl,
    output logic o_sda
);
timeunit 1ns;
timeprecision 1ns;
// Wired-and with pull-ups; a peer hold on SCL also stretches the clock
assign o_scl = !(i_scl_oe || i_pull_scl);
assign o_sda = !(i_sda_oe || i_pull_sda);
endmodule // icb_bus_model

// File: sim/tb_top.sv
/* Bench for icb_master: register tasks, condition table, SPI clock timing.
   Assumes icb_map.vh on the include path. */
`include "icb_map.vh"
module tb_top;
timeunit 1ns;
timeprecision 1ns;
logic i_clk_sys = 1'b0;
logic i_rst = 1'b1;
logic [3:0] i_addr = 4'h0;
logic [7:0] i_wdata = 8'h00;
logic i_wr = 1'b0;
logic i_rd = 1'b0;
logic pull_scl = 1'b0;
logic pull_sda = 1'b0;
logic i_scl, i_sda, o_scl_oe, o_sda_oe, o_scl_o, o_sda_o, o_irq;
logic [7:0] o_rdata;
int miscompares = 0;
int check_count = 0;
int cyc = 0;
int p3, p7, n;
always #20 i_clk_sys = ~i_clk_sys;
icb_master icb_master_i (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_scl, .i_sda, .o_scl_oe, .o_sda_oe, .o_scl_o, .o_sda_o, .o_irq);
icb_bus_model icb_bus_model_i (.i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe),
    .i_pull_scl(pull_scl), .i_pull_sda(pull_sda), .o_scl(i_scl), .o_sda(i_sda));
////////////////////////////////////////
task automatic give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
        miscompares++;
        $display("ERROR %s expected %h seen %h", s, e, g);
    end
endtask
task automatic cy(int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
endtask
task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
endtask
task automatic rd(logic [3:0] a, logic [7:0] e, string s);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(s, e, o_rdata);
endtask
// Runs one condition; f: 1 peer holds SDA, 2 peer pulls SCL at k, 3 peer pulls SDA at k
task automatic cond(logic [7:0] c, int f, int at, logic [7:0] mk, logic [7:0] e, logic [1:0] oe, string s);
    int k;
    wr(`ICB_ADDR_INT_MASK, mk);
    pull_sda <= (f == 1);
    wr(`ICB_ADDR_CTRL, c);
    for (k = 0; k < 300 && o_irq !== 1'b1; k++) begin
        @(posedge i_clk_sys);
        if (k == at) pull_scl <= (f == 2);
        if (k == at) pull_sda <= (f == 1 || f == 3);
        #1;
    end
    rd(`ICB_ADDR_INT_STAT, e, s);
    chk("lines", {6'h00, oe}, {6'h00, o_scl_oe, o_sda_oe});
    rd(`ICB_ADDR_CTRL, 8'h00, "ctrl");
    wr(`ICB_ADDR_INT_MASK, 8'h03);
    cy(2);
    chk("irq", 8'h01, {7'h00, o_irq});
    wr(`ICB_ADDR_INT_STAT, e);
    cy(2);
    chk("irq clear", 8'h00, {7'h00, o_irq});
    pull_scl <= 1'b0;
    pull_sda <= 1'b0;
    $display("test %s done", s);
endtask
// Counts clock pulses of one buffer write and the cycles between the first two
task automatic spi(logic [7:0] r, output int p, output int m);
    int k, t;
    logic pv;
    wr(`ICB_ADDR_RELOAD, r);
    wr(`ICB_ADDR_BUF, 8'hFF);
    m = 0;
    p = 0;
    t = 0;
    cy(0);
    pv = o_scl_oe;
    for (k = 0; k < 600; k++) begin
        cy(1);
        if (o_scl_oe === 1'b1 && pv === 1'b0) m++;
        if (o_scl_oe === 1'b1 && pv === 1'b0 && m == 1) t = k;
        if (o_scl_oe === 1'b1 && pv === 1'b0 && m == 2) p = k - t;
        pv = o_scl_oe;
    end
    $display("test spi reload %h done", r);
endtask
////////////////////////////////////////
always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
        miscompares++;
        give_verdict();
    end
end
initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(`ICB_ADDR_RELOAD, `ICB_RELOAD_RST, "reload");
    rd(`ICB_ADDR_STATUS, `ICB_STATUS_RST, "status");
    rd(`ICB_ADDR_INT_STAT, 8'h00, "int_stat");
    rd(4'hF, 8'h00, "unmapped");
    $display("test reset done");
    // Smallest reload allowed for two-wire use
    wr(`ICB_ADDR_RELOAD, 8'h03);
    cond(8'h01, 0, 0, 8'h03, 8'h02, 2'b11, "rep start");
    cond(8'h01, 1, 0, 8'h02, 8'h01, 2'b00, "rep sda low");
    cond(8'h01, 2, 15, 8'h03, 8'h01, 2'b00, "rep scl low");
    cond(8'h01, 3, 15, 8'h03, 8'h02, 2'b11, "rep late sda");
    cond(8'h02, 0, 0, 8'h03, 8'h02, 2'b00, "stop");
    rd(`ICB_ADDR_STATUS, 8'h10, "stop seen");
    cond(8'h02, 1, 0, 8'h03, 8'h01, 2'b00, "stop sda low");
    cond(8'h02, 2, 5, 8'h03, 8'h01, 2'b00, "stop scl low");
    wr(`ICB_ADDR_CTRL, 8'h04);
    spi(8'h03, p3, n);
    chk("pulses", 8'h08, 8'(n));
    chk("period", 8'h10, 8'(p3));
    spi(8'h07, p7, n);
    chk("pulses", 8'h08, 8'(n));
    chk("period step", 8'(2 * 4 * `ICB_CLK_PER_CNT), 8'(p7 - p3));
    give_verdict();
end
endmodule // tb_top
bind icb_master icb_master_props icb_master_props_i (.*);
